// >>> src/thermal_pkg.sv
// Purpose: Shared constants for the core thermal status and event block.
// Assumes: Two 64-bit model-specific registers reached through a select bit.
// Notes:   Bit positions are register field positions; widths are field widths.
`default_nettype none

package thermal_pkg;

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  localparam int       REG_W        = 64;
  localparam logic     SEL_STATUS   = 1'b0;
  localparam logic     SEL_IRQ_CTRL = 1'b1;

  // ----------------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------------
  localparam int ST_HOT      = 0;
  localparam int ST_HOT_LOG  = 1;
  localparam int ST_EXT      = 2;
  localparam int ST_EXT_LOG  = 3;
  localparam int ST_CRIT     = 4;
  localparam int ST_CRIT_LOG = 5;
  localparam int ST_T1       = 6;
  localparam int ST_T1_LOG   = 7;
  localparam int ST_T2       = 8;
  localparam int ST_T2_LOG   = 9;
  localparam int ST_PL       = 10;
  localparam int ST_PL_LOG   = 11;
  localparam int ST_READ_LO  = 16;
  localparam int ST_READ_HI  = 22;
  localparam int ST_RES_LO   = 27;
  localparam int ST_RES_HI   = 30;
  localparam int ST_VALID    = 31;

  // ----------------------------------------------------------------------
  // Interrupt control register fields
  // ----------------------------------------------------------------------
  localparam int IC_HIGH_EN  = 0;
  localparam int IC_LOW_EN   = 1;
  localparam int IC_HOT_EN   = 2;
  localparam int IC_FORCE_EN = 3;
  localparam int IC_CRIT_EN  = 4;
  localparam int IC_T1_LO    = 8;
  localparam int IC_T1_HI    = 14;
  localparam int IC_T1_EN    = 15;
  localparam int IC_T2_LO    = 16;
  localparam int IC_T2_HI    = 22;
  localparam int IC_T2_EN    = 23;
  localparam int IC_PL_EN    = 24;

  localparam logic [REG_W-1:0] IC_WRITE_MASK = 64'h0000_0000_01FF_FF1F;
  localparam logic [REG_W-1:0] IC_RESET      = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // Sticky log vector layout
  // ----------------------------------------------------------------------
  localparam int LOG_N    = 6;
  localparam int LOG_HOT  = 0;
  localparam int LOG_EXT  = 1;
  localparam int LOG_CRIT = 2;
  localparam int LOG_T1   = 3;
  localparam int LOG_T2   = 4;
  localparam int LOG_PL   = 5;

  // ----------------------------------------------------------------------
  // Event source vector layout
  // ----------------------------------------------------------------------
  localparam int EV_N     = 7;
  localparam int EV_HOT   = 0;
  localparam int EV_EXT   = 1;
  localparam int EV_FORCE = 2;
  localparam int EV_CRIT  = 3;
  localparam int EV_T1    = 4;
  localparam int EV_T2    = 5;
  localparam int EV_PL    = 6;

endpackage : thermal_pkg

`default_nettype wire

// >>> src/sticky_log.sv
// Purpose: Bank of sticky log bits with set and clear per bit.
// Assumes: Set and clear are synchronous to clk.
// Notes:   A set in the same cycle as a clear wins, so no event is lost.
`default_nettype none

module sticky_log #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clear,
  output logic      [W-1:0] log_bits
);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      log_bits <= '0;
    end else begin
      log_bits <= (log_bits & ~clear) | set;
    end
  end

endmodule : sticky_log

`default_nettype wire

// >>> src/level_edge.sv
// Purpose: Rising and falling edge detection on a vector of levels.
// Assumes: Levels are already synchronous to clk.
// Notes:   Edges are one-cycle pulses, combinational from the stored level.
`default_nettype none

module level_edge #(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule : level_edge

`default_nettype wire

// >>> src/core_thermal_status_and_interrupt.sv
// Purpose: Per-core thermal status, sticky logs, threshold compare and event generation.
// Assumes: All inputs are synchronous to clk; registers are reached by a 64-bit MSR port.
// Notes:   Thermal events are one-cycle pulses toward the local vector entry.
//
// What this block does
// - External hot or force pin sets log bit 3.
// - External hot pin ignored unless bidirectional enabled.
// - Bit 4 tracks live critical detector output.
// - Bit 5 logs critical detector assertion, sticky.
// - Bit 6 high while temperature at threshold one.
// - Bit 7 logs threshold one reached, sticky.
// - Bit 8 high while temperature at threshold two.
// - Bit 9 logs threshold two reached, sticky.
// - Bit 10 shows live power limitation when supported.
// - Bit 11 logs power limitation when supported.
// - Bits 22:16 give degrees below activation temperature.
// - Bits 30:27 give sensor resolution in degrees.
// - Bit 31 set only when readout is valid.
// - Enable bit 0 raises event on heating.
// - Enable bit 1 raises event on cooling.
// - Enable bit 2 raises event on external hot.
// - Enable bit 3 raises event on force pin.
// - Enable bit 4 raises event on critical.
// - Threshold one compare; bit 15 enables crossing events.
// - Threshold two compare; bit 23 enables crossing events.
// - Enable bit 24 raises power limit event.
// - Bit 0 reflects own hot pin drive.
// - Bit 1 logs own hot pin assertion, sticky.
// - Bit 2 high while external hot or force.
`default_nettype none

module core_thermal_status_and_interrupt #(
  parameter int TEMP_W = 7,
  parameter int RES_W  = 4
) (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // Register port.
  input  wire logic                           msr_wr,
  input  wire logic                           msr_rd,
  input  wire logic                           msr_sel,
  input  wire logic [thermal_pkg::REG_W-1:0]  msr_wdata,
  output logic      [thermal_pkg::REG_W-1:0]  msr_rdata,
  output logic                                msr_rvalid,
  // Sensor side.
  input  wire logic                           sensor_hot,
  input  wire logic                           critical_temp,
  input  wire logic [TEMP_W-1:0]              temp_readout,
  input  wire logic                           readout_valid,
  input  wire logic [RES_W-1:0]               sensor_resolution,
  // Platform and core side.
  input  wire logic                           bidir_hot_enable,
  input  wire logic                           power_limit_notify_supported,
  input  wire logic                           below_requested_perf,
  input  wire logic                           force_throttle_pin_n,
  input  wire logic                           hot_indicator_pin_i_n,
  output logic                                hot_indicator_pin_o_n,
  output logic                                hot_indicator_pin_oe,
  // Toward the local vector entry.
  output logic                                thermal_event
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // A smaller readout is hotter, so "at or above the threshold" is readout <= value.
  function automatic logic reached(input logic [TEMP_W-1:0] readout,
                                   input logic [TEMP_W-1:0] thr,
                                   input logic              valid);
    reached = valid && (readout <= thr);
  endfunction : reached

  // ----------------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------------
  logic                 s_hot;
  logic                 s_crit;
  logic [TEMP_W-1:0]    s_readout;
  logic                 s_valid;
  logic [RES_W-1:0]     s_res;
  logic                 s_bidir;
  logic                 s_pl_sup;
  logic                 s_below;
  logic                 s_force;
  logic                 s_pin_low;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_hot     <= 1'b0;
      s_crit    <= 1'b0;
      s_readout <= '0;
      s_valid   <= 1'b0;
      s_res     <= '0;
      s_bidir   <= 1'b0;
      s_pl_sup  <= 1'b0;
      s_below   <= 1'b0;
      s_force   <= 1'b0;
      s_pin_low <= 1'b0;
    end else begin
      s_hot     <= sensor_hot;
      s_crit    <= critical_temp;
      s_readout <= temp_readout;
      s_valid   <= readout_valid;
      s_res     <= sensor_resolution;
      s_bidir   <= bidir_hot_enable;
      s_pl_sup  <= power_limit_notify_supported;
      s_below   <= below_requested_perf;
      s_force   <= ~force_throttle_pin_n;
      s_pin_low <= ~hot_indicator_pin_i_n;
    end
  end

  // ----------------------------------------------------------------------
  // Hot indicator drive
  // ----------------------------------------------------------------------
  // The pin is open drain: it is pulled low while the sensor reports hot.
  logic drove_pin;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hot_indicator_pin_oe  <= 1'b0;
      hot_indicator_pin_o_n <= 1'b1;
      drove_pin             <= 1'b0;
    end else begin
      hot_indicator_pin_oe  <= s_hot;
      hot_indicator_pin_o_n <= ~s_hot;
      drove_pin             <= hot_indicator_pin_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt control register
  // ----------------------------------------------------------------------
  logic [thermal_pkg::REG_W-1:0] irq_ctrl;
  logic                          wr_status;
  logic                          wr_irq;

  assign wr_status = msr_wr && (msr_sel == thermal_pkg::SEL_STATUS);
  assign wr_irq    = msr_wr && (msr_sel == thermal_pkg::SEL_IRQ_CTRL);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ctrl <= thermal_pkg::IC_RESET;
    end else if (wr_irq) begin
      irq_ctrl <= msr_wdata & thermal_pkg::IC_WRITE_MASK;
    end
  end

  logic [TEMP_W-1:0] thr_one;
  logic [TEMP_W-1:0] thr_two;

  assign thr_one = irq_ctrl[thermal_pkg::IC_T1_HI:thermal_pkg::IC_T1_LO];
  assign thr_two = irq_ctrl[thermal_pkg::IC_T2_HI:thermal_pkg::IC_T2_LO];

  // ----------------------------------------------------------------------
  // Live status
  // ----------------------------------------------------------------------
  logic ext_hot;
  logic live_ext;
  logic live_t1;
  logic live_t2;
  logic live_pl;

  // bidirectional gate plus own-drive mask
  // A low pin while this core is not driving it is another agent's assertion.
  assign ext_hot  = s_bidir && s_pin_low && !drove_pin;
  assign live_ext = ext_hot || s_force;
  assign live_t1  = reached(s_readout, thr_one, s_valid);
  assign live_t2  = reached(s_readout, thr_two, s_valid);
  assign live_pl  = s_pl_sup && s_below;

  // ----------------------------------------------------------------------
  // Sticky logs
  // ----------------------------------------------------------------------
  logic [thermal_pkg::LOG_N-1:0] log_set;
  logic [thermal_pkg::LOG_N-1:0] log_clear;
  logic [thermal_pkg::LOG_N-1:0] log_bits;

  always_comb begin
    log_set                        = '0;
    log_set[thermal_pkg::LOG_HOT]  = hot_indicator_pin_oe;
    log_set[thermal_pkg::LOG_EXT]  = live_ext;
    log_set[thermal_pkg::LOG_CRIT] = s_crit;
    log_set[thermal_pkg::LOG_T1]   = live_t1;
    log_set[thermal_pkg::LOG_T2]   = live_t2;
    log_set[thermal_pkg::LOG_PL]   = live_pl;
  end

  always_comb begin
    log_clear                        = '0;
    log_clear[thermal_pkg::LOG_HOT]  = wr_status && !msr_wdata[thermal_pkg::ST_HOT_LOG];
    log_clear[thermal_pkg::LOG_EXT]  = wr_status && !msr_wdata[thermal_pkg::ST_EXT_LOG];
    log_clear[thermal_pkg::LOG_CRIT] = wr_status && !msr_wdata[thermal_pkg::ST_CRIT_LOG];
    log_clear[thermal_pkg::LOG_T1]   = wr_status && !msr_wdata[thermal_pkg::ST_T1_LOG];
    log_clear[thermal_pkg::LOG_T2]   = wr_status && !msr_wdata[thermal_pkg::ST_T2_LOG];
    log_clear[thermal_pkg::LOG_PL]   = wr_status && !msr_wdata[thermal_pkg::ST_PL_LOG];
  end

  sticky_log #(
    .W (thermal_pkg::LOG_N)
  ) u_logs (
    .clk      (clk),
    .rstn     (rstn),
    .set      (log_set),
    .clear    (log_clear),
    .log_bits (log_bits)
  );

  // ----------------------------------------------------------------------
  // Status register image
  // ----------------------------------------------------------------------
  logic [thermal_pkg::REG_W-1:0] status_image;

  always_comb begin
    status_image                          = '0;
    status_image[thermal_pkg::ST_HOT]     = hot_indicator_pin_oe;
    status_image[thermal_pkg::ST_HOT_LOG] = log_bits[thermal_pkg::LOG_HOT];
    status_image[thermal_pkg::ST_EXT]     = live_ext;
    status_image[thermal_pkg::ST_EXT_LOG] = log_bits[thermal_pkg::LOG_EXT];
    status_image[thermal_pkg::ST_CRIT]     = s_crit;
    status_image[thermal_pkg::ST_CRIT_LOG] = log_bits[thermal_pkg::LOG_CRIT];
    status_image[thermal_pkg::ST_T1]      = live_t1;
    status_image[thermal_pkg::ST_T1_LOG]  = log_bits[thermal_pkg::LOG_T1];
    status_image[thermal_pkg::ST_T2]      = live_t2;
    status_image[thermal_pkg::ST_T2_LOG]  = log_bits[thermal_pkg::LOG_T2];
    status_image[thermal_pkg::ST_PL]      = live_pl;
    status_image[thermal_pkg::ST_PL_LOG]  = log_bits[thermal_pkg::LOG_PL];
    status_image[thermal_pkg::ST_READ_HI:thermal_pkg::ST_READ_LO] = s_readout;
    status_image[thermal_pkg::ST_RES_HI:thermal_pkg::ST_RES_LO]   = s_res;
    status_image[thermal_pkg::ST_VALID]   = s_valid;
  end

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msr_rdata  <= '0;
      msr_rvalid <= 1'b0;
    end else begin
      msr_rvalid <= msr_rd;
      if (msr_rd) begin
        msr_rdata <= (msr_sel == thermal_pkg::SEL_STATUS) ? status_image : irq_ctrl;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Thermal events
  // ----------------------------------------------------------------------
  logic [thermal_pkg::EV_N-1:0] ev_level;
  logic [thermal_pkg::EV_N-1:0] ev_rise;
  logic [thermal_pkg::EV_N-1:0] ev_fall;
  logic                         next_event;

  always_comb begin
    ev_level                        = '0;
    ev_level[thermal_pkg::EV_HOT]   = hot_indicator_pin_oe;
    ev_level[thermal_pkg::EV_EXT]   = ext_hot;
    ev_level[thermal_pkg::EV_FORCE] = s_force;
    ev_level[thermal_pkg::EV_CRIT]  = s_crit;
    ev_level[thermal_pkg::EV_T1]    = live_t1;
    ev_level[thermal_pkg::EV_T2]    = live_t2;
    ev_level[thermal_pkg::EV_PL]    = live_pl;
  end

  level_edge #(
    .W (thermal_pkg::EV_N)
  ) u_edges (
    .clk   (clk),
    .rstn  (rstn),
    .level (ev_level),
    .rise  (ev_rise),
    .fall  (ev_fall)
  );

  always_comb begin
    next_event = 1'b0;
    if (irq_ctrl[thermal_pkg::IC_HIGH_EN] && ev_rise[thermal_pkg::EV_HOT]) begin
      next_event = 1'b1;
    end
    if (irq_ctrl[thermal_pkg::IC_LOW_EN] && ev_fall[thermal_pkg::EV_HOT]) begin
      next_event = 1'b1;
    end
    if (irq_ctrl[thermal_pkg::IC_HOT_EN] && ev_rise[thermal_pkg::EV_EXT]) begin
      next_event = 1'b1;
    end
    if (irq_ctrl[thermal_pkg::IC_FORCE_EN] && ev_rise[thermal_pkg::EV_FORCE]) begin
      next_event = 1'b1;
    end
    if (irq_ctrl[thermal_pkg::IC_CRIT_EN] && ev_rise[thermal_pkg::EV_CRIT]) begin
      next_event = 1'b1;
    end
    if (irq_ctrl[thermal_pkg::IC_T1_EN]
        && (ev_rise[thermal_pkg::EV_T1] || ev_fall[thermal_pkg::EV_T1])) begin
      next_event = 1'b1;
    end
    if (irq_ctrl[thermal_pkg::IC_T2_EN]
        && (ev_rise[thermal_pkg::EV_T2] || ev_fall[thermal_pkg::EV_T2])) begin
      next_event = 1'b1;
    end
    if (irq_ctrl[thermal_pkg::IC_PL_EN] && ev_rise[thermal_pkg::EV_PL]) begin
      next_event = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      thermal_event <= 1'b0;
    end else begin
      thermal_event <= next_event;
    end
  end

endmodule : core_thermal_status_and_interrupt

`default_nettype wire

// >>> verification/core_thermal_chk.sv
// Purpose: Port-level checks of the core thermal block.
// Assumes: Interrupt control changes only through the register port.
// Notes:   Interrupt control is shadowed from observed writes.
`default_nettype none

module core_thermal_chk #(
  parameter int TEMP_W = 7,
  parameter int RES_W  = 4
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              msr_wr,
  input wire logic              msr_rd,
  input wire logic              msr_sel,
  input wire logic [63:0]       msr_wdata,
  input wire logic [63:0]       msr_rdata,
  input wire logic              msr_rvalid,
  input wire logic              sensor_hot,
  input wire logic              critical_temp,
  input wire logic [TEMP_W-1:0] temp_readout,
  input wire logic              readout_valid,
  input wire logic [RES_W-1:0]  sensor_resolution,
  input wire logic              force_throttle_pin_n,
  input wire logic              hot_indicator_pin_o_n,
  input wire logic              hot_indicator_pin_oe,
  input wire logic              thermal_event
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [63:0] ic_shadow;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ic_shadow <= thermal_pkg::IC_RESET;
    end else if (msr_wr && msr_sel == thermal_pkg::SEL_IRQ_CTRL) begin
      ic_shadow <= msr_wdata & thermal_pkg::IC_WRITE_MASK;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  sequence status_read_s;
    msr_rd && !msr_wr && msr_sel == thermal_pkg::SEL_STATUS && $past(rstn);
  endsequence
  sequence ic_read_s;
    msr_rd && !msr_wr && msr_sel == thermal_pkg::SEL_IRQ_CTRL;
  endsequence
  sequence event_soon_s;
    ##[1:3] thermal_event;
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_read_answer: assert property (msr_rd |=> msr_rvalid)
    else $error("read without answer");
  a_answer_cause: assert property (msr_rvalid |-> $past(msr_rd))
    else $error("answer without read");
  a_rdata_hold: assert property (!msr_rvalid |-> $stable(msr_rdata))
    else $error("read data moved without answer");
  a_ctrl_readback: assert property (ic_read_s |=> msr_rdata == ic_shadow)
    else $error("control readback wrong");
  a_readout_fields: assert property (status_read_s |=>
    msr_rdata[31] == $past(readout_valid, 2) && msr_rdata[30:27] == $past(sensor_resolution, 2)
    && msr_rdata[22:16] == $past(temp_readout, 2))
    else $error("readout fields wrong");
  a_crit_live: assert property (status_read_s |=> msr_rdata[4] == $past(critical_temp, 2))
    else $error("critical status wrong");
  a_pin_rise: assert property (sensor_hot |-> ##2 hot_indicator_pin_oe)
    else $error("pin not driven");
  a_pin_release: assert property (!sensor_hot |-> ##2 !hot_indicator_pin_oe)
    else $error("pin not released");
  a_pin_low: assert property (hot_indicator_pin_oe |-> !hot_indicator_pin_o_n)
    else $error("pin driven high");
  a_crit_event: assert property ($rose(critical_temp) && ic_shadow[4] |-> event_soon_s)
    else $error("critical event missing");
  a_force_event: assert property ($fell(force_throttle_pin_n) && ic_shadow[3] |-> event_soon_s)
    else $error("force event missing");
  a_masked_quiet: assert property ((ic_shadow == 64'h0)[*4] |-> !thermal_event)
    else $error("event while all masked");

endmodule : core_thermal_chk

bind core_thermal_status_and_interrupt core_thermal_chk #(
  .TEMP_W(TEMP_W), .RES_W(RES_W)
) chk_u (
  .clk, .rstn, .msr_wr, .msr_rd, .msr_sel, .msr_wdata, .msr_rdata, .msr_rvalid, .sensor_hot,
  .critical_temp, .temp_readout, .readout_valid, .sensor_resolution, .force_throttle_pin_n,
  .hot_indicator_pin_o_n, .hot_indicator_pin_oe, .thermal_event
);

`default_nettype wire

// >>> verification/thermal_platform_model.sv
// Purpose: Platform agents and interrupt controller facing the thermal block.
// Assumes: The shared hot pin has a pull-up; any driver pulls it low.
// Notes:   Each clock with the event high counts as one event.
`default_nettype none

module thermal_platform_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ext_hot,
  input  wire logic ext_force,
  input  wire logic hot_indicator_pin_o_n,
  input  wire logic hot_indicator_pin_oe,
  input  wire logic thermal_event,
  output logic      force_throttle_pin_n,
  output logic      hot_indicator_pin_i_n,
  output int        event_count
);
  timeunit 1ns;
  timeprecision 1ps;

  assign hot_indicator_pin_i_n = !(ext_hot || (hot_indicator_pin_oe && !hot_indicator_pin_o_n));
  assign force_throttle_pin_n  = !ext_force;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_count <= 0;
    end else if (thermal_event) begin
      event_count <= event_count + 1;
    end
  end

endmodule : thermal_platform_model

`default_nettype wire

// >>> verification/test_core_thermal_status_and_interrupt.sv
// Purpose: Register-level tests of the core thermal block.
// Assumes: Inputs change at the falling edge; reads answer one cycle later.
// Notes:   Events are counted by the platform model and compared as deltas.
`default_nettype none

module test_core_thermal_status_and_interrupt;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic STS = thermal_pkg::SEL_STATUS;
  localparam logic IRQ = thermal_pkg::SEL_IRQ_CTRL;

  logic        clk, rstn, msr_wr, msr_rd, msr_sel, msr_rvalid;
  logic [63:0] msr_wdata, msr_rdata, rd;
  logic        sensor_hot, critical_temp, readout_valid, bidir_hot_enable;
  logic        power_limit_notify_supported, below_requested_perf, ext_hot, ext_force;
  logic [6:0]  temp_readout;
  logic [3:0]  sensor_resolution;
  logic        force_throttle_pin_n, hot_indicator_pin_i_n, hot_indicator_pin_o_n;
  logic        hot_indicator_pin_oe, thermal_event;
  int          num_errors, tests_run, cycles, ev_mark, event_count;

  core_thermal_status_and_interrupt dut_u (
    .clk, .rstn, .msr_wr, .msr_rd, .msr_sel, .msr_wdata, .msr_rdata, .msr_rvalid, .sensor_hot,
    .critical_temp, .temp_readout, .readout_valid, .sensor_resolution, .bidir_hot_enable,
    .power_limit_notify_supported, .below_requested_perf, .force_throttle_pin_n,
    .hot_indicator_pin_i_n, .hot_indicator_pin_o_n, .hot_indicator_pin_oe, .thermal_event
  );

  thermal_platform_model model_u (
    .clk, .rstn, .ext_hot, .ext_force, .hot_indicator_pin_o_n, .hot_indicator_pin_oe,
    .thermal_event, .force_throttle_pin_n, .hot_indicator_pin_i_n, .event_count
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic msr_write(input logic sel, input logic [63:0] data);
    @(negedge clk);
    {msr_wr, msr_sel, msr_wdata} = {1'b1, sel, data};
    @(negedge clk);
    msr_wr = 1'b0;
  endtask : msr_write

  task automatic msr_read(input logic sel, output logic [63:0] data);
    @(negedge clk);
    {msr_rd, msr_sel} = {1'b1, sel};
    @(negedge clk);
    msr_rd = 1'b0;
    check({63'h0, msr_rvalid}, 64'h1, "read answer");
    data = msr_rdata;
  endtask : msr_read

  // Waits for inputs to settle, then checks flags and new events.
  task automatic expect_flags(input logic [11:0] flags, input int events);
    repeat (6) @(negedge clk);
    msr_read(STS, rd);
    check({52'h0, rd[11:0]}, {52'h0, flags}, "status flags");
    check(64'(event_count - ev_mark), 64'(events), "event count");
    ev_mark = event_count;
  endtask : expect_flags

  task automatic test_done(input string name);
    $display("test %s done, mismatches so far %0d", name, num_errors);
  endtask : test_done

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    {rstn, msr_wr, msr_rd, msr_sel, sensor_hot, critical_temp} = '0;
    {bidir_hot_enable, power_limit_notify_supported, below_requested_perf} = '0;
    {ext_hot, ext_force, msr_wdata} = '0;
    {temp_readout, readout_valid, sensor_resolution} = {7'h28, 1'b1, 4'h2};
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    msr_read(STS, rd);
    check(rd, 64'h9028_0000, "status reset");
    msr_read(IRQ, rd);
    check(rd, thermal_pkg::IC_RESET, "control reset");
    msr_write(STS, '1);
    msr_read(STS, rd);
    check(rd, 64'h9028_0000, "status read-only");
    msr_write(IRQ, '1);
    msr_read(IRQ, rd);
    check(rd, thermal_pkg::IC_WRITE_MASK, "control mask");
    msr_write(IRQ, 64'h0);
    msr_write(STS, 64'h0);
    expect_flags(12'h000, 1);
    test_done("registers");

    msr_write(IRQ, 64'h18);
    ext_force = 1'b1;
    expect_flags(12'h00C, 1);
    ext_force = 1'b0;
    expect_flags(12'h008, 0);
    critical_temp = 1'b1;
    expect_flags(12'h038, 1);
    critical_temp = 1'b0;
    expect_flags(12'h028, 0);
    msr_write(STS, ~64'h20);
    expect_flags(12'h008, 0);
    msr_write(STS, 64'h0);
    expect_flags(12'h000, 0);
    msr_write(IRQ, 64'h0);
    ext_force = 1'b1;
    expect_flags(12'h00C, 0);
    ext_force = 1'b0;
    msr_write(STS, 64'h0);
    test_done("force and critical");

    msr_write(IRQ, 64'h04);
    ext_hot = 1'b1;
    expect_flags(12'h000, 0);
    bidir_hot_enable = 1'b1;
    expect_flags(12'h00C, 1);
    {ext_hot, bidir_hot_enable} = 2'b00;
    msr_write(STS, 64'h0);
    expect_flags(12'h000, 0);
    test_done("external hot");

    msr_write(IRQ, 64'h03);
    sensor_hot = 1'b1;
    expect_flags(12'h003, 1);
    check({62'h0, hot_indicator_pin_oe, hot_indicator_pin_i_n}, 64'h2, "pin drive");
    sensor_hot = 1'b0;
    expect_flags(12'h002, 1);
    msr_write(STS, 64'h0);
    expect_flags(12'h000, 0);
    test_done("own hot");

    msr_write(IRQ, 64'h00BC_9400);
    expect_flags(12'h300, 1);
    temp_readout = 7'h0A;
    expect_flags(12'h3C0, 1);
    temp_readout = 7'h28;
    expect_flags(12'h380, 1);
    temp_readout = 7'h46;
    expect_flags(12'h280, 1);
    temp_readout = 7'h3C;
    expect_flags(12'h380, 1);
    readout_valid = 1'b0;
    expect_flags(12'h280, 1);
    check({63'h0, rd[31]}, 64'h0, "valid bit");
    msr_write(IRQ, 64'h0);
    {readout_valid, temp_readout} = {1'b1, 7'h28};
    msr_write(STS, 64'h0);
    expect_flags(12'h000, 0);
    test_done("thresholds");

    msr_write(IRQ, 64'h0100_0000);
    below_requested_perf = 1'b1;
    expect_flags(12'h000, 0);
    power_limit_notify_supported = 1'b1;
    expect_flags(12'hC00, 1);
    below_requested_perf = 1'b0;
    expect_flags(12'h800, 0);
    msr_write(STS, 64'h0);
    expect_flags(12'h000, 0);
    test_done("power limit");
    final_report();
  end

endmodule : test_core_thermal_status_and_interrupt

`default_nettype wire
